//--- adc_defines.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the antenna diversity and converter control block.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH

// ==========================================================
// Register offsets
// ==========================================================
`define ADC_OFF_CFG_INDEX   8'h18
`define ADC_OFF_CFG_DATA    8'h19
`define ADC_OFF_ANT_CTRL    8'h1A
`define ADC_OFF_APPROX      8'h1B
`define ADC_OFF_RSSI_LIMIT  8'h1C

// ==========================================================
// Field positions
// ==========================================================
`define ADC_BIT_BUSY        7
`define ADC_BIT_LOCKED      6
`define ADC_BIT_SEL_OUT     5
`define ADC_BIT_SWITCH      4
`define ADC_BIT_SW_EN       3
`define ADC_BIT_DAC_MODE    2
`define ADC_BIT_SRC_SEL     1
`define ADC_BIT_START       0
`define ADC_BIT_ACTIVE      7
`define ADC_BIT_EXT_START   7
`define ADC_BIT_EXT_EN      6
`define ADC_BIT_APPROX_EN   5
`define ADC_BIT_PIN_FUNC    7

// ==========================================================
// Indirect register indices
// ==========================================================
`define ADC_IDX_CONV_CFG    6'h19
`define ADC_IDX_ANT_CFG     6'h1E

// ==========================================================
// Reset values
// ==========================================================
`define ADC_RST_ANT_CTRL    8'h00
`define ADC_RST_CFG_INDEX   6'h00
`define ADC_RST_LIMIT       7'h00

// ==========================================================
// Converter modes
// ==========================================================
`define ADC_MODE_INT_A      3'h0
`define ADC_MODE_INT_B      3'h1
`define ADC_MODE_INT_C      3'h2
`define ADC_MODE_EXT        3'h3
`define ADC_MODE_DAC        3'h4
`define ADC_MODE_RSVD       3'h7

// ==========================================================
// Timing: approximation step time in ns and its cycle count
// ==========================================================
`define ADC_STEP_NS         16
`define ADC_CLK_NS          8
`define ADC_STEP_CYC        ((`ADC_STEP_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

//--- adc_sar_engine.v
/*
 * Successive approximation engine: seven steps, one bit per step,
 * driven by an external comparator result.
 * Assumes the comparator input is synchronous to ref_clk.
 */
`include "adc_defines.vh"
`default_nettype none

module adc_sar_engine #(
   parameter WIDTH    = 7,
   parameter STEP_CYC = `ADC_STEP_CYC
) (
   input  wire             ref_clk,
   input  wire             rstn,
   input  wire             start,
   input  wire             comp_in,
   output reg              busy_ff,
   output reg  [WIDTH-1:0] value_ff
);

   // ==========================================================
   // Step state
   // ==========================================================
   reg [3:0]       bit_ff;
   reg [7:0]       wait_ff;
   reg [WIDTH-1:0] nxt_value;

   // Comparator result into the current bit, trial one into the next lower bit
   always @* begin
      nxt_value = value_ff;
      nxt_value[bit_ff[2:0]] = comp_in;
      if (bit_ff != 4'h0)
         nxt_value[bit_ff[2:0] - 3'h1] = 1'b1;
   end

   // Start ignored while busy; step timer and bit walk
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busy_ff  <= 1'b0;
         bit_ff   <= 4'h0;
         wait_ff  <= 8'h00;
         value_ff <= {WIDTH{1'b0}};
      end else if (!busy_ff) begin
         if (start) begin
            busy_ff  <= 1'b1;
            bit_ff   <= WIDTH[3:0] - 4'h1;
            wait_ff  <= STEP_CYC[7:0];
            value_ff <= {1'b1, {(WIDTH-1){1'b0}}};
         end
      end else if (wait_ff != 8'h01) begin
         wait_ff <= wait_ff - 8'h01;
      end else begin
         value_ff <= nxt_value;
         wait_ff  <= STEP_CYC[7:0];
         if (bit_ff == 4'h0)
            busy_ff <= 1'b0;
         else
            bit_ff <= bit_ff - 4'h1;
      end
   end

endmodule

`default_nettype wire

//--- adc_antenna_ctrl.v
/*
 * Antenna diversity and converter control register slice with an
 * indirect configuration port, antenna select pins and converter control.
 * Assumes a simple one-cycle register port and synchronous inputs.
 */
// Our own choices: the register offsets and the address-and-strobe port.
`include "adc_defines.vh"
`default_nettype none

module adc_antenna_ctrl #(
   parameter IDX_COUNT = 64
) (
   input  wire       ref_clk,
   input  wire       rstn,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata_ff,
   input  wire       receive_start_bit,
   input  wire       carrier_detect,
   input  wire       antenna_criteria_met,
   input  wire       diversity_antenna,
   input  wire       bus_mode_strap,
   input  wire       comparator_in,
   input  wire       ext_conv_done,
   input  wire [6:0] ext_approx_in,
   output reg        antenna_select_out_ff,
   output reg        antenna_select_out_n_ff,
   output reg        antenna_pins_active_ff,
   output reg        analog_input_sel_ff,
   output reg  [6:0] approx_pins_ff,
   output reg        approx_pins_drive_ff,
   output reg        rssi_above_limit_ff,
   output reg  [2:0] converter_mode_ff
);

   // ==========================================================
   // Storage
   // ==========================================================
   reg [5:0] cfg_index_ff;
   reg [7:0] cfg_mem_ff [0:IDX_COUNT-1];
   reg       busy_flag_ff;
   reg       locked_flag_ff;
   reg       switch_bit_ff;
   reg       switch_en_ff;
   reg       dac_sel_ff;
   reg       src_sel_ff;
   reg       start_bit_ff;
   reg [6:0] rssi_limit_ff;
   reg [6:0] dac_value_ff;
   reg       rx_start_d_ff;
   reg       sar_busy_d_ff;
   wire      sar_busy;
   wire [6:0] sar_value;
   integer   i;

   // Decode mode from the four mode bits
   function [2:0] decode_mode;
      input dac;
      input ext;
      input sar_en;
      input ext_start;
      begin
         if (dac)
            decode_mode = sar_en ? `ADC_MODE_DAC : `ADC_MODE_RSVD;
         else if (ext)
            decode_mode = sar_en ? `ADC_MODE_RSVD : `ADC_MODE_EXT;
         else if (!sar_en)
            decode_mode = ext_start ? `ADC_MODE_RSVD : `ADC_MODE_INT_A;
         else
            decode_mode = ext_start ? `ADC_MODE_INT_C : `ADC_MODE_INT_B;
      end
   endfunction

   // Internal mode test
   function is_internal;
      input [2:0] mode;
      begin
         is_internal = (mode == `ADC_MODE_INT_A) ||
                       (mode == `ADC_MODE_INT_B) ||
                       (mode == `ADC_MODE_INT_C);
      end
   endfunction

   // ==========================================================
   // Mode and pin function decode
   // ==========================================================
   wire [7:0] conv_cfg = cfg_mem_ff[`ADC_IDX_CONV_CFG];
   wire [7:0] ant_cfg  = cfg_mem_ff[`ADC_IDX_ANT_CFG];
   wire [2:0] mode_now = decode_mode(dac_sel_ff,
                                     conv_cfg[`ADC_BIT_EXT_EN],
                                     conv_cfg[`ADC_BIT_APPROX_EN],
                                     conv_cfg[`ADC_BIT_EXT_START]);
   wire       internal_mode = is_internal(mode_now);
   wire       dac_mode = (mode_now == `ADC_MODE_DAC);
   wire       pin_func = ant_cfg[`ADC_BIT_PIN_FUNC];
   // Pins act as antenna select unless strap is set and both function bit and switch enable are clear
   wire       pins_active = switch_en_ff | pin_func | ~bus_mode_strap;
   // Software control when enabled, else diversity decision
   wire       ant_level = switch_en_ff ? switch_bit_ff
                                       : diversity_antenna;

   wire wr_ctrl   = reg_wr && (reg_addr == `ADC_OFF_ANT_CTRL);
   wire wr_approx = reg_wr && (reg_addr == `ADC_OFF_APPROX);
   wire wr_data   = reg_wr && (reg_addr == `ADC_OFF_CFG_DATA);
   // Start only on a one written; zero is harmless
   wire start_req = wr_ctrl && reg_wdata[`ADC_BIT_START] &&
                    internal_mode;

   // ==========================================================
   // Conversion engine
   // ==========================================================
   adc_sar_engine #(
      .WIDTH    (7),
      .STEP_CYC (`ADC_STEP_CYC)
   ) u_sar (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .start    (start_req),
      .comp_in  (comparator_in),
      .busy_ff  (sar_busy),
      .value_ff (sar_value)
   );

   wire [6:0] conv_value = (mode_now == `ADC_MODE_EXT) ? ext_approx_in
                                                       : sar_value;
   wire       conv_active = sar_busy;
   wire       conv_done = (sar_busy_d_ff & ~sar_busy) |
                          ((mode_now == `ADC_MODE_EXT) & ext_conv_done);

   // ==========================================================
   // Indirect configuration registers
   // ==========================================================
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_index_ff <= `ADC_RST_CFG_INDEX;
         for (i = 0; i < IDX_COUNT; i = i + 1)
            cfg_mem_ff[i] <= 8'h00;
      end else begin
         if (reg_wr && (reg_addr == `ADC_OFF_CFG_INDEX))
            cfg_index_ff <= reg_wdata[5:0];
         if (wr_data)
            cfg_mem_ff[cfg_index_ff] <= reg_wdata;
      end
   end

   // ==========================================================
   // Control register and flags
   // ==========================================================
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         locked_flag_ff <= 1'b0;
         switch_bit_ff  <= 1'b0;
         switch_en_ff   <= 1'b0;
         dac_sel_ff     <= 1'b0;
         src_sel_ff     <= 1'b0;
         start_bit_ff   <= 1'b0;
         busy_flag_ff   <= 1'b0;
         rx_start_d_ff  <= 1'b0;
         sar_busy_d_ff  <= 1'b0;
      end else begin
         rx_start_d_ff <= receive_start_bit;
         sar_busy_d_ff <= sar_busy;
         // Hardware only; writes ignored
         busy_flag_ff  <= carrier_detect;
         // Receive start wins over a lock in the same cycle
         if (receive_start_bit && !rx_start_d_ff)
            locked_flag_ff <= 1'b0;
         else if (antenna_criteria_met)
            locked_flag_ff <= 1'b1;
         if (wr_ctrl) begin
            switch_bit_ff <= reg_wdata[`ADC_BIT_SWITCH];
            switch_en_ff  <= reg_wdata[`ADC_BIT_SW_EN];
            dac_sel_ff    <= reg_wdata[`ADC_BIT_DAC_MODE];
            src_sel_ff    <= reg_wdata[`ADC_BIT_SRC_SEL];
            start_bit_ff  <= reg_wdata[`ADC_BIT_START];
         end
      end
   end

   // ==========================================================
   // Limit register and DAC value
   // ==========================================================
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rssi_limit_ff <= `ADC_RST_LIMIT;
         dac_value_ff  <= 7'h00;
      end else begin
         if (reg_wr && (reg_addr == `ADC_OFF_RSSI_LIMIT))
            rssi_limit_ff <= reg_wdata[6:0];
         if (wr_approx && dac_mode)
            dac_value_ff <= reg_wdata[6:0];
      end
   end

   // ==========================================================
   // Pin outputs
   // ==========================================================
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         antenna_select_out_ff   <= 1'b0;
         antenna_select_out_n_ff <= 1'b1;
         antenna_pins_active_ff  <= 1'b0;
         analog_input_sel_ff     <= 1'b0;
         approx_pins_ff          <= 7'h00;
         approx_pins_drive_ff    <= 1'b0;
         rssi_above_limit_ff     <= 1'b0;
         converter_mode_ff       <= `ADC_MODE_INT_A;
      end else begin
         antenna_select_out_ff   <= ant_level;
         antenna_select_out_n_ff <= ~ant_level;
         antenna_pins_active_ff  <= pins_active;
         if (internal_mode)
            analog_input_sel_ff <= src_sel_ff;
         if (dac_mode)
            approx_pins_ff <= dac_value_ff;
         approx_pins_drive_ff    <= dac_mode;
         if (conv_done)
            rssi_above_limit_ff <= (conv_value >= rssi_limit_ff);
         converter_mode_ff       <= mode_now;
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   // ==========================================================
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADC_OFF_CFG_INDEX:  reg_rdata_ff <= {2'b00, cfg_index_ff};
            `ADC_OFF_CFG_DATA:   reg_rdata_ff <= cfg_mem_ff[cfg_index_ff];
            `ADC_OFF_ANT_CTRL:   reg_rdata_ff <= {busy_flag_ff,
                                                  locked_flag_ff,
                                                  antenna_select_out_ff,
                                                  switch_bit_ff,
                                                  switch_en_ff,
                                                  dac_sel_ff,
                                                  src_sel_ff,
                                                  start_bit_ff};
            `ADC_OFF_APPROX:     reg_rdata_ff <= {conv_active,
                                                  conv_value};
            `ADC_OFF_RSSI_LIMIT: reg_rdata_ff <= {rssi_above_limit_ff,
                                                  rssi_limit_ff};
            default:             reg_rdata_ff <= 8'h00;
         endcase
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end

endmodule

`default_nettype wire

//--- adc_ctrl_asserts.sv
/* Port-level checker for the antenna and converter control block.
   Assumes it is bound onto adc_antenna_ctrl and adc_defines.vh is found. */
`include "adc_defines.vh"
`default_nettype none
module adc_ctrl_asserts #(
   parameter IDX_COUNT = 64
) (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic       carrier_detect,
   input wire logic       antenna_select_out_ff,
   input wire logic       antenna_select_out_n_ff,
   input wire logic       analog_input_sel_ff,
   input wire logic [6:0] approx_pins_ff,
   input wire logic       approx_pins_drive_ff,
   input wire logic [2:0] converter_mode_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Access decode
   // ==========================================================
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire logic rd_ctl = reg_rd && (reg_addr == `ADC_OFF_ANT_CTRL);
   wire logic wr_ctl = reg_wr && (reg_addr == `ADC_OFF_ANT_CTRL);
   wire logic wr_apx = reg_wr && (reg_addr == `ADC_OFF_APPROX);
   wire logic is_dac = (converter_mode_ff == `ADC_MODE_DAC);
   // ==========================================================
   // Assertions
   // ==========================================================
   AST_BUSY_FOLLOW: assert property (
      rd_ctl |=> reg_rdata_ff[7] == $past(carrier_detect, 2))
      else $error("busy flag does not follow carrier");
   AST_SEL_READBACK: assert property (
      (rd_ctl && $stable(antenna_select_out_ff)) ##1
      $stable(antenna_select_out_ff)
      |-> reg_rdata_ff[5] == antenna_select_out_ff)
      else $error("select bit differs from pin");
   AST_SEL_PAIR: assert property (
      antenna_select_out_n_ff != antenna_select_out_ff)
      else $error("select pair not complementary");
   AST_SWITCH_DRIVE: assert property (
      (wr_ctl && reg_wdata[3]) ##1 !wr_ctl
      |=> antenna_select_out_ff == $past(reg_wdata[4], 2))
      else $error("switch bit not on select pin");
   AST_MODE_LEGAL: assert property (
      converter_mode_ff inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7})
      else $error("illegal converter mode code");
   AST_SRC_FROZEN: assert property (
      (converter_mode_ff >= `ADC_MODE_EXT) && $stable(converter_mode_ff)
      |-> $stable(analog_input_sel_ff))
      else $error("input select moved outside internal mode");
   AST_DAC_DRIVE: assert property (
      wr_apx && is_dac |-> ##2 approx_pins_ff == $past(reg_wdata[6:0], 2))
      else $error("field write not on pins in dac mode");
   AST_DAC_HOLD: assert property (
      wr_apx && !is_dac && !approx_pins_drive_ff |=> $stable(approx_pins_ff))
      else $error("field write moved pins outside dac mode");
   // Main scenarios reached
   cover property (wr_ctl && reg_wdata[0]);
   cover property (wr_apx && is_dac);
   cover property (converter_mode_ff == `ADC_MODE_EXT);
endmodule
bind adc_antenna_ctrl adc_ctrl_asserts #(.IDX_COUNT(IDX_COUNT)) u_asserts (.*);
`default_nettype wire

//--- adc_afe_model.sv
/* Analog front end model: two RSSI inputs feeding the comparator.
   Assumes the bench sets each input level against any trial value. */
`default_nettype none
module adc_afe_model (
   input wire logic  input_sel,
   input wire logic  level_one,
   input wire logic  level_two,
   output var logic  comparator_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Selected input decides the comparator result
   always_comb begin
      comparator_in = input_sel ? level_two : level_one;
   end
endmodule
`default_nettype wire

//--- tb.sv
/* Register-level bench for the antenna and converter control block.
   Assumes the design files, the checker and the front end model. */
`include "adc_defines.vh"
`default_nettype none
`define ADC_CHK(nm, exp, got) begin checks++; \
   if ((got) !== (exp)) begin errors++; \
   $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_ff, d;
   logic       rx_start = 0, carrier = 0, criteria = 0, div_ant = 0;
   logic       lvl_one = 1, lvl_two = 0, comp, sel, sel_out, sel_n, drive;
   logic       above, act;
   logic [6:0] apx, p;
   logic [2:0] mode;
   int         errors = 0, checks = 0, cycles = 0;
   logic [7:0] ix[3] = '{8'h05, 8'h3F, 8'h00};
   logic [7:0] dv[3] = '{8'hA5, 8'h3C, 8'h5A};
   logic [7:0] m_cfg[8] = '{8'h00, 8'h80, 8'h20, 8'hA0,
                            8'h40, 8'h60, 8'h00, 8'h20};
   logic [2:0] m_exp[8] = '{3'h0, 3'h7, 3'h1, 3'h2, 3'h3, 3'h7, 3'h7, 3'h4};
   // Design and front end
   adc_antenna_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .receive_start_bit(rx_start), .carrier_detect(carrier),
      .antenna_criteria_met(criteria), .diversity_antenna(div_ant),
      .bus_mode_strap(1'b0), .comparator_in(comp), .ext_conv_done(1'b0),
      .ext_approx_in(7'h00), .antenna_select_out_ff(sel_out),
      .antenna_select_out_n_ff(sel_n), .antenna_pins_active_ff(act),
      .analog_input_sel_ff(sel), .approx_pins_ff(apx),
      .approx_pins_drive_ff(drive), .rssi_above_limit_ff(above),
      .converter_mode_ff(mode));
   adc_afe_model u_afe (.input_sel(sel), .level_one(lvl_one),
      .level_two(lvl_two), .comparator_in(comp));
   // Clock and hang guard
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         finish_test;
      end
   end
   // ==========================================================
   // Bus tasks
   // ==========================================================
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata_ff;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic finish_test;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // Test sequence
   // ==========================================================
   initial begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(`ADC_OFF_ANT_CTRL, d);
      `ADC_CHK("ctrl reset", `ADC_RST_ANT_CTRL, d)
      `ADC_CHK("sel_n reset", 1'b1, sel_n)
      // Indirect port, top index included
      for (int i = 0; i < 3; i++) begin
         wr(`ADC_OFF_CFG_INDEX, ix[i]);
         wr(`ADC_OFF_CFG_DATA, dv[i]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(`ADC_OFF_CFG_INDEX, ix[i]);
         rd(`ADC_OFF_CFG_DATA, d);
         `ADC_CHK("cfg data", dv[i], d)
      end
      // Busy flag against firmware writes
      @(posedge ref_clk) carrier <= 1'b1;
      wr(`ADC_OFF_ANT_CTRL, 8'h00);
      rd(`ADC_OFF_ANT_CTRL, d);
      `ADC_CHK("busy set", 1'b1, d[7])
      @(posedge ref_clk) carrier <= 1'b0;
      wr(`ADC_OFF_ANT_CTRL, 8'h80);
      rd(`ADC_OFF_ANT_CTRL, d);
      `ADC_CHK("busy write", 1'b0, d[7])
      // Locked flag set, then cleared by receive start
      @(posedge ref_clk) criteria <= 1'b1;
      @(posedge ref_clk) criteria <= 1'b0;
      rd(`ADC_OFF_ANT_CTRL, d);
      `ADC_CHK("locked set", 1'b1, d[6])
      @(posedge ref_clk) rx_start <= 1'b1;
      rd(`ADC_OFF_ANT_CTRL, d);
      `ADC_CHK("locked clear", 1'b0, d[6])
      @(posedge ref_clk) rx_start <= 1'b0;
      // Antenna switch under software control, then diversity
      wr(`ADC_OFF_ANT_CTRL, 8'h18);
      tick(2);
      `ADC_CHK("switch on", 1'b1, sel_out)
      rd(`ADC_OFF_ANT_CTRL, d);
      `ADC_CHK("select read", 1'b1, d[5])
      wr(`ADC_OFF_ANT_CTRL, 8'h10);
      tick(2);
      `ADC_CHK("switch disabled", 1'b0, sel_out)
      @(posedge ref_clk) div_ant <= 1'b1;
      tick(3);
      `ADC_CHK("diversity pin", 1'b1, sel_out)
      `ADC_CHK("pins active", 1'b1, act)
      @(posedge ref_clk) div_ant <= 1'b0;
      // Every converter mode code
      for (int i = 0; i < 8; i++) begin
         wr(`ADC_OFF_CFG_INDEX, {2'b00, `ADC_IDX_CONV_CFG});
         wr(`ADC_OFF_CFG_DATA, m_cfg[i]);
         wr(`ADC_OFF_ANT_CTRL, (i >= 6) ? 8'h04 : 8'h00);
         tick(3);
         `ADC_CHK("mode", m_exp[i], mode)
      end
      // Approximation pins only in dac mode
      wr(`ADC_OFF_APPROX, 8'h55);
      tick(1);
      `ADC_CHK("dac pins", 7'h55, apx)
      `ADC_CHK("dac drive", 1'b1, drive)
      wr(`ADC_OFF_CFG_DATA, 8'h00);
      wr(`ADC_OFF_ANT_CTRL, 8'h00);
      tick(3);
      p = apx;
      wr(`ADC_OFF_APPROX, 8'h2A);
      tick(2);
      `ADC_CHK("pins held", p, apx)
      `ADC_CHK("drive off", 1'b0, drive)
      // Conversions on each input, second during receive start
      wr(`ADC_OFF_RSSI_LIMIT, 8'h40);
      wr(`ADC_OFF_ANT_CTRL, 8'h01);
      rd(`ADC_OFF_APPROX, d);
      `ADC_CHK("active", 1'b1, d[7])
      tick(20);
      rd(`ADC_OFF_APPROX, d);
      `ADC_CHK("value one", 8'h7F, d)
      `ADC_CHK("above limit", 1'b1, above)
      `ADC_CHK("input one", 1'b0, sel)
      @(posedge ref_clk) rx_start <= 1'b1;
      wr(`ADC_OFF_ANT_CTRL, 8'h03);
      tick(20);
      rd(`ADC_OFF_APPROX, d);
      `ADC_CHK("value two", 8'h00, d)
      `ADC_CHK("below limit", 1'b0, above)
      `ADC_CHK("input two", 1'b1, sel)
      @(posedge ref_clk) rx_start <= 1'b0;
      wr(`ADC_OFF_ANT_CTRL, 8'h02);
      rd(`ADC_OFF_APPROX, d);
      `ADC_CHK("zero start", 8'h00, d)
      finish_test;
   end
endmodule
`default_nettype wire
